// file: hw/fwsc_ctrl.sv
// Frequency word store, select logic and AHB-Lite register slave
`timescale 1ns/100ps
`include "fwsc_defs.svh"
module fwsc_ctrl import fwsc_pkg::*; #(
  // Programmed contents; values are arbitrary
  parameter logic [`FWSC_MEM_BYTES*8-1:0] PROG_WORDS = {`FWSC_MEM_BYTES{8'h5a}},
  parameter logic [`FWSC_SEL_W-1:0] PROG_SEL = 2'h0,
  parameter logic PROG_PIN_SELECT = 1'h0,
  parameter logic PROG_PIN_PD = 1'h0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic freq_sel_hi_i,
  input wire logic freq_sel_lo_i,
  input wire logic ctrl_pin_i,
  output fwsc_synth_cfg_t synth_cfg_o,
  output logic synth_load_o,
  output logic pll_lock_o,
  output logic clk_out_en_o,
  output logic power_down_o
);
  localparam int RELOCK_CYC = (`FWSC_RELOCK_NS * `FWSC_CLK_MHZ + 999) / 1000;

  fwsc_state_t state, next_state;
  logic [`FWSC_MEM_AW-1:0] ld_cnt, next_ld_cnt;
  logic [7:0] mem [`FWSC_MEM_BYTES];
  logic [7:0] next_mem [`FWSC_MEM_BYTES];
  logic [`FWSC_SEL_W-1:0] sel_reg, next_sel;
  logic ap_valid, next_ap_valid;
  logic ap_write, next_ap_write;
  logic [`FWSC_IDX_W-1:0] ap_idx, next_ap_idx;
  logic [31:0] hrdata, next_hrdata;

  fwsc_synth_cfg_t synth_cfg, next_cfg;
  logic cfg_valid, next_cfg_valid;
  logic synth_load, next_load;
  logic [`FWSC_RELOCK_W-1:0] relock, next_relock;
  fwsc_status_t stat, next_stat;

  logic [2:0] pins_s;
  logic [`FWSC_SEL_W-1:0] pin_sel;
  logic ctrl_s;
  logic [`FWSC_SEL_W-1:0] eff_sel;
  logic pd_req;
  logic oe;
  logic take;
  logic addr_ok;
  logic [`FWSC_IDX_W-1:0] idx;
  logic [`FWSC_MEM_AW-1:0] rd_off;
  logic [`FWSC_MEM_AW-1:0] wr_off;
  logic [31:0] rd_val;

  fwsc_pin_sync #(
    .W(3),
    .RST_VAL(`FWSC_PIN_RST)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({freq_sel_hi_i, freq_sel_lo_i, ctrl_pin_i}),
    .q_o(pins_s)
  );

  assign pin_sel = pins_s[2:1];
  assign ctrl_s = pins_s[0];
  assign eff_sel = PROG_PIN_SELECT ? pin_sel : sel_reg;
  assign pd_req = PROG_PIN_PD && !ctrl_s;
  assign oe = PROG_PIN_PD || ctrl_s;

  // Word assembly, lowest address is the most significant byte
  function automatic logic [`FWSC_WORD_W-1:0] word_of(input logic [`FWSC_SEL_W-1:0] s,
                                                      input logic [7:0] m [`FWSC_MEM_BYTES]);
    logic [`FWSC_WORD_W-1:0] w;
    logic [`FWSC_MEM_AW-1:0] base;
    w = '0;
    base = 5'({3'h0, s} * 5'(`FWSC_WORD_BYTES));
    for (int b = 0; b < `FWSC_WORD_BYTES; b++) begin
      w[(`FWSC_WORD_BYTES-1-b)*8 +: 8] = m[base + 5'(b)];
    end
    return w;
  endfunction

  // Address decode
  always_comb begin
    idx = haddr_i[`FWSC_ADDR_IDX_MSB:`FWSC_ADDR_IDX_LSB];
    addr_ok = (haddr_i[31:`FWSC_ADDR_HI_LSB] == '0) && (haddr_i[1:0] == 2'h0);
    take = hsel_i && hready_i && (htrans_i == `FWSC_HTRANS_NONSEQ) && (state == FWSC_RUN);
    rd_off = 5'(idx - `FWSC_IDX_WORD0);
    wr_off = 5'(ap_idx - `FWSC_IDX_WORD0);
    rd_val = 32'h0;
    if (addr_ok) begin
      if (idx >= `FWSC_IDX_WORD0 && idx <= `FWSC_IDX_WORD_END) begin
        rd_val = {24'h0, mem[rd_off]};
        if (ap_valid && ap_write && ap_idx == idx) begin
          rd_val = {24'h0, hwdata_i[7:0]};
        end
      end else if (idx == `FWSC_IDX_SELECT) begin
        rd_val = {30'h0, sel_reg};
        if (ap_valid && ap_write && ap_idx == idx) begin
          rd_val = {30'h0, hwdata_i[1:0]};
        end
      end else if (idx == `FWSC_IDX_CONFIG) begin
        rd_val = {30'h0, PROG_PIN_PD, PROG_PIN_SELECT};
      end else if (idx == `FWSC_IDX_STATUS) begin
        rd_val = {26'h0, stat, synth_cfg.index, cfg_valid};
      end
    end
  end

  // Power-on load, memory and bus registers
  always_comb begin
    next_state = state;
    next_ld_cnt = ld_cnt;
    next_mem = mem;
    next_sel = sel_reg;
    next_ap_valid = 1'h0;
    next_ap_write = 1'h0;
    next_ap_idx = ap_idx;
    next_hrdata = hrdata;
    unique case (state)
      FWSC_LOAD: begin
        next_mem[ld_cnt] = PROG_WORDS[{ld_cnt, 3'h0} +: 8];
        if (ld_cnt == 5'(`FWSC_MEM_BYTES - 1)) begin
          next_state = FWSC_RUN;
          next_sel = PROG_SEL;
        end else begin
          next_ld_cnt = ld_cnt + 5'h1;
        end
      end
      FWSC_RUN: begin
        if (ap_valid && ap_write) begin
          if (ap_idx >= `FWSC_IDX_WORD0 && ap_idx <= `FWSC_IDX_WORD_END) begin
            next_mem[wr_off] = hwdata_i[7:0];
          end else if (ap_idx == `FWSC_IDX_SELECT) begin
            next_sel = hwdata_i[1:0];
          end
        end
        if (take) begin
          next_ap_valid = 1'h1;
          next_ap_write = hwrite_i;
          next_ap_idx = addr_ok ? idx : `FWSC_IDX_UNMAPPED;
          if (!hwrite_i) begin
            next_hrdata = rd_val;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= FWSC_LOAD;
      ld_cnt <= '0;
      sel_reg <= '0;
      ap_valid <= 1'h0;
      ap_write <= 1'h0;
      ap_idx <= '0;
      hrdata <= 32'h0;
      for (int i = 0; i < `FWSC_MEM_BYTES; i++) begin
        mem[i] <= 8'h0;
      end
    end else begin
      state <= next_state;
      ld_cnt <= next_ld_cnt;
      mem <= next_mem;
      sel_reg <= next_sel;
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_idx <= next_ap_idx;
      hrdata <= next_hrdata;
    end
  end

  // Synthesizer word snapshot and lock tracking
  always_comb begin
    next_cfg = synth_cfg;
    next_cfg_valid = cfg_valid;
    next_load = 1'h0;
    next_relock = relock;
    if (state == FWSC_RUN && (!cfg_valid || eff_sel != synth_cfg.index)) begin
      next_cfg.word = word_of(eff_sel, mem);
      next_cfg.index = eff_sel;
      next_cfg_valid = 1'h1;
      next_load = 1'h1;
      next_relock = `FWSC_RELOCK_W'(RELOCK_CYC);
    end else if (pd_req) begin
      next_relock = `FWSC_RELOCK_W'(RELOCK_CYC);
    end else if (relock != '0) begin
      next_relock = relock - `FWSC_RELOCK_W'(1);
    end
    next_stat.lock = next_cfg_valid && (next_relock == '0) && !pd_req;
    next_stat.clk_en = next_stat.lock && oe;
    next_stat.power_down = pd_req;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      synth_cfg <= '0;
      cfg_valid <= 1'h0;
      synth_load <= 1'h0;
      relock <= '0;
      stat <= '0;
    end else begin
      synth_cfg <= next_cfg;
      cfg_valid <= next_cfg_valid;
      synth_load <= next_load;
      relock <= next_relock;
      stat <= next_stat;
    end
  end

  assign hreadyout_o = (state == FWSC_RUN);
  assign hresp_o = `FWSC_HRESP_OKAY;
  assign hrdata_o = hrdata;
  assign synth_cfg_o = synth_cfg;
  assign synth_load_o = synth_load;
  assign pll_lock_o = stat.lock;
  assign clk_out_en_o = stat.clk_en;
  assign power_down_o = stat.power_down;

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_load_len;
    (state == FWSC_LOAD && ld_cnt == '0) |-> ##24 (state == FWSC_RUN && hreadyout_o);
  endproperty
  a_load_len: assert property (p_load_len) else $error("load did not take 24 cycles");

  property p_load_data;
    (state == FWSC_RUN && $past(state) == FWSC_LOAD) |->
      (mem[0] == PROG_WORDS[7:0] && mem[23] == PROG_WORDS[191:184]);
  endproperty
  a_load_data: assert property (p_load_data) else $error("stored words not restored");

  property p_boot_sel;
    (state == FWSC_RUN && $past(state) == FWSC_LOAD) |-> (sel_reg == PROG_SEL) ##1 synth_load_o;
  endproperty
  a_boot_sel: assert property (p_boot_sel) else $error("power-on select wrong");

  property p_sel_write;
    (!PROG_PIN_SELECT && ap_valid && ap_write && ap_idx == `FWSC_IDX_SELECT) |->
      ##2 (synth_cfg_o.index == $past(hwdata_i[1:0], 2));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write not applied");

  property p_word_write;
    (ap_valid && ap_write && ap_idx >= `FWSC_IDX_WORD0 && ap_idx <= `FWSC_IDX_WORD_END) |=>
      (mem[$past(wr_off)] == $past(hwdata_i[7:0]));
  endproperty
  a_word_write: assert property (p_word_write) else $error("word byte not stored");

  property p_load_word;
    synth_load_o |-> (synth_cfg_o.word == $past(word_of(eff_sel, mem)));
  endproperty
  a_load_word: assert property (p_load_word) else $error("loaded word mismatch");

  property p_pin_sel;
    (PROG_PIN_SELECT && state == FWSC_RUN && cfg_valid && pin_sel != synth_cfg.index) |->
      ##1 (synth_load_o && synth_cfg_o.index == $past(pin_sel));
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("pin select not applied");

  property p_relock;
    synth_load_o |-> (!pll_lock_o && !clk_out_en_o) [*8];
  endproperty
  a_relock: assert property (p_relock) else $error("lock reported too early");

  property p_oe_gate;
    (!PROG_PIN_PD && !ctrl_s) |=> (!clk_out_en_o && !power_down_o);
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("enable pin did not gate clock");

  property p_pd;
    (PROG_PIN_PD && !ctrl_s) |=> (power_down_o && !pll_lock_o && !clk_out_en_o);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down not entered");

  c_sel_write: cover property (ap_valid && ap_write && ap_idx == `FWSC_IDX_SELECT);
  c_lock: cover property ($rose(pll_lock_o));
  c_wake: cover property ($fell(power_down_o));
  c_switch: cover property (synth_load_o && synth_cfg_o.index == 2'h3);
endmodule

// file: hw/fwsc_defs.svh
// Constants for the frequency word select control block
`ifndef FWSC_DEFS_SVH
`define FWSC_DEFS_SVH

`define FWSC_WORD_BYTES 6
`define FWSC_NUM_WORDS 4
`define FWSC_MEM_BYTES 24
`define FWSC_MEM_AW 5
`define FWSC_WORD_W 48
`define FWSC_SEL_W 2
`define FWSC_IDX_W 8
`define FWSC_IDX_WORD0 8'h10
`define FWSC_IDX_WORD_END 8'h27
`define FWSC_IDX_SELECT 8'h40
`define FWSC_IDX_CONFIG 8'h48
`define FWSC_IDX_STATUS 8'h49
`define FWSC_IDX_UNMAPPED 8'hff
`define FWSC_ADDR_IDX_LSB 2
`define FWSC_ADDR_IDX_MSB 9
`define FWSC_ADDR_HI_LSB 10
`define FWSC_HTRANS_NONSEQ 2'h2
`define FWSC_HRESP_OKAY 1'h0
`define FWSC_RELOCK_NS 10000
`define FWSC_CLK_MHZ 125
`define FWSC_RELOCK_W 11
`define FWSC_PIN_RST 3'h1

`endif

// file: hw/fwsc_pkg.sv
// Types shared by the frequency word select control block
`include "fwsc_defs.svh"
package fwsc_pkg;

  typedef enum logic {
    FWSC_LOAD,
    FWSC_RUN
  } fwsc_state_t;

  typedef struct packed {
    logic [`FWSC_WORD_W-1:0] word;
    logic [`FWSC_SEL_W-1:0] index;
  } fwsc_synth_cfg_t;

  typedef struct packed {
    logic lock;
    logic clk_en;
    logic power_down;
  } fwsc_status_t;

endpackage

// file: hw/fwsc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module fwsc_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] q;
  logic [W-1:0] next_q;

  always_comb begin
    next_q = q;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_q[i] = s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q <= RST_VAL;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

  assign q_o = q;
endmodule

// file: verif/fwsc_host_pins.sv
// Host-side model driving the select and control pins
`timescale 1ns/100ps
module fwsc_host_pins (
  input wire logic ref_clk_i,
  output logic freq_sel_hi_o,
  output logic freq_sel_lo_o,
  output logic ctrl_pin_o
);
  initial begin
    freq_sel_hi_o = 1'h0;
    freq_sel_lo_o = 1'h0;
    ctrl_pin_o = 1'h1;
  end
  // Pins hi then lo form the word number
  task set_sel(input logic [1:0] s);
    @(posedge ref_clk_i);
    freq_sel_hi_o <= s[1];
    freq_sel_lo_o <= s[0];
  endtask
  // Enable high, power-down low
  task set_ctrl(input logic v);
    @(posedge ref_clk_i);
    ctrl_pin_o <= v;
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the frequency word select control
`timescale 1ns/100ps
module testbench import fwsc_pkg::*;;
  logic ref_clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [31:0] hrdata2;
  logic [2:0] hsize = 3'h0;
  logic hsel2 = 1'h0, tgt = 1'h0;
  logic hready, hresp, hr2, load, lock, en, pdn, load2, lock2, en2, pdn2, fs_hi, fs_lo, ctrl;
  fwsc_synth_cfg_t cfg, cfg2;
  int err_count = 0, cmp_count = 0;
  function automatic logic [191:0] mkpw();
    for (int k = 0; k < 24; k++) mkpw[k*8+:8] = 8'ha0 + k[7:0];
  endfunction
  function automatic logic [47:0] wv(input int n, input logic [7:0] b);
    wv = '0;
    for (int i = 0; i < 6; i++) wv = {wv[39:0], b + 8'(6 * n + i)};
  endfunction
  always #4 ref_clk = ~ref_clk;
  fwsc_host_pins u_host (.ref_clk_i(ref_clk), .freq_sel_hi_o(fs_hi), .freq_sel_lo_o(fs_lo), .ctrl_pin_o(ctrl));
  fwsc_ctrl #(.PROG_WORDS(mkpw()), .PROG_SEL(2'h1)) u_dut (
    .ref_clk_i(ref_clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .freq_sel_hi_i(fs_hi), .freq_sel_lo_i(fs_lo), .ctrl_pin_i(ctrl), .synth_cfg_o(cfg),
    .synth_load_o(load), .pll_lock_o(lock), .clk_out_en_o(en), .power_down_o(pdn));
  fwsc_ctrl #(.PROG_WORDS(mkpw()), .PROG_PIN_SELECT(1'h1), .PROG_PIN_PD(1'h1)) u_pin (
    .ref_clk_i(ref_clk), .rst_i(rst), .hsel_i(hsel2), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hr2), .hreadyout_o(hr2), .hresp_o(),
    .hrdata_o(hrdata2), .freq_sel_hi_i(fs_hi), .freq_sel_lo_i(fs_lo), .ctrl_pin_i(ctrl), .synth_cfg_o(cfg2),
    .synth_load_o(load2), .pll_lock_o(lock2), .clk_out_en_o(en2), .power_down_o(pdn2));
  task close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_on(input int which, input int lim);
    int n;
    n = 0;
    while ((which == 0 ? hready : which == 1 ? lock : which == 2 ? lock2 : load) !== 1'h1) begin
      @(posedge ref_clk);
      n++;
      if (n > lim) begin
        err_count++;
        close_out();
      end
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= !tgt;
    hsel2 <= tgt;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge ref_clk);
    wait_on(0, 50);
    hsel <= 1'h0;
    hsel2 <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    wait_on(0, 50);
    rd = tgt ? hrdata2 : hrdata;
  endtask
  task boot();
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    wait_on(0, 100);
    wait_on(1, 2000);
    chk(cfg, {wv(1, 8'ha0), 2'h1});
    ahb(1'h0, 32'h100, 32'h0);
    chk(rd, 32'h1);
    chk(hresp, 1'h0);
  endtask
  task t_sel();
    for (int i = 0; i < 6; i++) ahb(1'h1, 32'h70 + 4 * i, 32'h3c + i);
    ahb(1'h1, 32'h100, 32'h2);
    wait_on(3, 5);
    @(posedge ref_clk);
    chk(cfg, {wv(2, 8'h30), 2'h2});
    chk({lock, en}, 2'h0);
    wait_on(1, 1300);
    chk(en, 1'h1);
    ahb(1'h0, 32'h124, 32'h0);
    chk(rd, 32'h35);
    ahb(1'h0, 32'h70, 32'h0);
    chk(rd, 32'h3c);
    ahb(1'h1, 32'h3fc, 32'h55);
    ahb(1'h0, 32'h3fc, 32'h0);
    chk(rd, 32'h0);
  endtask
  task t_ctrl();
    u_host.set_ctrl(1'h0);
    repeat (8) @(posedge ref_clk);
    chk({en, lock, pdn}, 3'h2);
    chk({pdn2, en2}, 2'h2);
    u_host.set_ctrl(1'h1);
    repeat (8) @(posedge ref_clk);
    chk({en, pdn2, lock2}, 3'h4);
    wait_on(2, 1300);
    chk(en2, 1'h1);
  endtask
  task t_pins();
    for (int s = 0; s < 4; s++) begin
      u_host.set_sel(s[1:0]);
      repeat (8) @(posedge ref_clk);
      chk(cfg2, {wv(s, 8'ha0), s[1:0]});
    end
    tgt = 1'h1;
    ahb(1'h0, 32'h120, 32'h0);
    chk(rd, 32'h3);
    ahb(1'h1, 32'h100, 32'h0);
    repeat (4) @(posedge ref_clk);
    chk(cfg2.index, 2'h3);
    tgt = 1'h0;
  endtask
  task t_rst();
    rst <= 1'h1;
    boot();
    ahb(1'h0, 32'h70, 32'h0);
    chk(rd, 32'hac);
  endtask
  initial begin
    boot();
    t_sel();
    t_ctrl();
    t_pins();
    t_rst();
    close_out();
  end
endmodule
